// ---- lfhp_consts.svh ----
// Purpose: constants for the line feed host port
// Assumes: included by bare name
// Notes:   offsets, field positions, reset values and timing counts
`ifndef LFHP_CONSTS_SVH
`define LFHP_CONSTS_SVH

`define LFHP_SEL_OFFSET       1'h0
`define LFHP_ENREQ_OFFSET     1'h1
`define LFHP_IRQ_EN_BIT       3
`define LFHP_CODE_MSB         2
`define LFHP_SEL_RESET        4'h0
`define LFHP_ENREQ_RESET      4'h0
`define LFHP_CODE_PWRON       3'h0
`define LFHP_CODE_OPENLP      3'h1
`define LFHP_CODE_CUROVL      3'h2
`define LFHP_CODE_ENCTL       3'h3
`define LFHP_CODE_RSV0        3'h4
`define LFHP_CODE_RSV1        3'h5
`define LFHP_CODE_ENREQ       3'h6
`define LFHP_CODE_THERM       3'h7
`define LFHP_CLK_MHZ          250
`define LFHP_REREAD_WAIT_US   1000
`define LFHP_REREAD_WAIT_CYC  (`LFHP_REREAD_WAIT_US * `LFHP_CLK_MHZ)

`endif

// ---- lfhp_pkg.sv ----
// Purpose: types for the line feed host port
// Assumes: constants come from lfhp_consts.svh
// Notes:   status selection codes as an enum
package lfhp_pkg;
   typedef enum logic [2:0] {
      LFHP_STAT_PWRON  = 3'b000,
      LFHP_STAT_OPENLP = 3'b001,
      LFHP_STAT_CUROVL = 3'b010,
      LFHP_STAT_ENCTL  = 3'b011,
      LFHP_STAT_RSV0   = 3'b100,
      LFHP_STAT_RSV1   = 3'b101,
      LFHP_STAT_ENREQ  = 3'b110,
      LFHP_STAT_THERM  = 3'b111
   } lfhp_status_sel_t;

   typedef enum logic [1:0] {
      LFHP_ACC_IDLE  = 2'b00,
      LFHP_ACC_WRITE = 2'b01,
      LFHP_ACC_READ  = 2'b10
   } lfhp_access_t;
endpackage

// ---- lfhp_reg4.sv ----
// Purpose: four-bit register with load strobe
// Assumes: asynchronous active-low reset
// Notes:   used for the select and enable request registers
`timescale 1ns/1ps
module lfhp_reg4 #(
   parameter logic [3:0] RESET_VAL = 4'h0
) (
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       load_i,
   input  wire logic [3:0] data_i,
   output logic      [3:0] q_o
);
   logic [3:0] q_d;
   logic [3:0] q_q;

   always_comb begin
      q_d = load_i ? data_i : q_q;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q_q <= RESET_VAL;
      end else begin
         q_q <= q_d;
      end
   end

   assign q_o = q_q;
endmodule

// ---- lfhp_host_port.sv ----
// Operation
// [RL1] low select bits pick status type read
// [RL2] select bit three enables interrupt generation
// [RL3] interrupt low when any overload and enabled
// [RL4] interrupt high once all overload flags low
// [RL5] reset input low forces interrupt high
// [RL6] select-low read returns stored selection code
// [RL7] read bit three shows over-temperature flag
// [RL8] decode strobes; chip select high means nothing
// [RL9] select-high read returns chosen status bits
// [RL10] enable request bits per channel, copied on accept
// [RL11] register select latched on address strobe fall
// [RL12] host waits 1 ms before status reread
// [RL13] data bus undriven while chip select high
// [RL14] drive only on read; reserved codes zero
//
// Purpose: four-bit processor port of a quad line feed controller
// Assumes: strobes are synchronous to clk_i; detectors are inputs
// Notes:   write takes effect on the write strobe rising edge
`timescale 1ns/1ps
`include "lfhp_consts.svh"
module lfhp_host_port (
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       reset_in_n_i,
   input  wire logic       chip_select_n_i,
   input  wire logic       read_strobe_n_i,
   input  wire logic       write_strobe_n_i,
   input  wire logic       register_select_i,
   input  wire logic       addr_latch_i,
   input  wire logic       addr_latch_tied_i,
   input  wire logic [3:0] data_i,
   input  wire logic [3:0] power_on_phase_flag_i,
   input  wire logic [3:0] open_loop_flag_i,
   input  wire logic [3:0] current_overload_flag_i,
   input  wire logic [3:0] thermal_overload_flag_i,
   input  wire logic [3:0] request_accept_i,
   input  wire logic       over_temp_i,
   output logic      [3:0] data_o,
   output logic      [3:0] data_oe_o,
   output logic      [3:0] enable_request_o,
   output logic      [3:0] enable_control_o,
   output logic            interrupt_out_n_o
);
   logic [3:0] sel_reg;
   logic [3:0] enreq_reg;
   logic       ale_q, ale_d;
   logic       rsel_q, rsel_d;
   logic       rsel_eff;
   logic       wr_q, wr_d;
   logic       wr_fire;
   logic       sel_load, enreq_load;
   logic [3:0] wdat_q, wdat_d;
   logic [3:0] dout_q, dout_d;
   logic [3:0] doe_q, doe_d;
   logic [3:0] lec_q, lec_d;
   logic       irq_n_q, irq_n_d;
   logic [3:0] status_word;
   lfhp_pkg::lfhp_access_t acc;

   // selected address: latched on strobe fall, or live when strobe is tied
   assign rsel_eff = addr_latch_tied_i ? register_select_i : rsel_q; // [RL11]

   always_comb begin
      ale_d  = addr_latch_i;
      rsel_d = rsel_q;
      if (ale_q && !addr_latch_i) begin
         rsel_d = register_select_i; // [RL11]
      end
   end

   // access decode; no access at all while chip select is high
   always_comb begin
      acc = lfhp_pkg::LFHP_ACC_IDLE;
      if (!chip_select_n_i) begin // [RL8]
         if (read_strobe_n_i && !write_strobe_n_i) begin
            acc = lfhp_pkg::LFHP_ACC_WRITE;
         end else if (!read_strobe_n_i && write_strobe_n_i) begin
            acc = lfhp_pkg::LFHP_ACC_READ;
         end
      end
   end

   // commit on strobe release so data settled during the whole pulse counts
   always_comb begin
      wr_d   = (acc == lfhp_pkg::LFHP_ACC_WRITE);
      wdat_d = wr_d ? data_i : wdat_q;
   end
   assign wr_fire    = wr_q && (acc != lfhp_pkg::LFHP_ACC_WRITE);
   assign sel_load   = wr_fire && (rsel_eff == `LFHP_SEL_OFFSET);   // [RL8]
   assign enreq_load = wr_fire && (rsel_eff == `LFHP_ENREQ_OFFSET); // [RL8] [RL10]

   lfhp_reg4 #(
      .RESET_VAL (`LFHP_SEL_RESET)
   ) u_sel (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .load_i   (sel_load),
      .data_i   (wdat_q),
      .q_o      (sel_reg)
   );

   lfhp_reg4 #(
      .RESET_VAL (`LFHP_ENREQ_RESET)
   ) u_enreq (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .load_i   (enreq_load),
      .data_i   (wdat_q),
      .q_o      (enreq_reg)
   );

   // status multiplexer by selection code
   always_comb begin
      case (lfhp_pkg::lfhp_status_sel_t'(sel_reg[`LFHP_CODE_MSB:0])) // [RL1]
         lfhp_pkg::LFHP_STAT_PWRON:  status_word = power_on_phase_flag_i;
         lfhp_pkg::LFHP_STAT_OPENLP: status_word = open_loop_flag_i;
         lfhp_pkg::LFHP_STAT_CUROVL: status_word = current_overload_flag_i;
         lfhp_pkg::LFHP_STAT_ENCTL:  status_word = lec_q;
         lfhp_pkg::LFHP_STAT_ENREQ:  status_word = enreq_reg;
         lfhp_pkg::LFHP_STAT_THERM:  status_word = thermal_overload_flag_i;
         default:                    status_word = 4'h0; // [RL14]
      endcase
   end

   // read data path, driven only during a read
   always_comb begin
      dout_d = 4'h0;
      doe_d  = 4'h0; // [RL13]
      if (acc == lfhp_pkg::LFHP_ACC_READ) begin // [RL14]
         doe_d = 4'hf;
         if (rsel_eff == `LFHP_SEL_OFFSET) begin
            dout_d = {over_temp_i, sel_reg[`LFHP_CODE_MSB:0]}; // [RL6] [RL7]
         end else begin
            dout_d = status_word; // [RL9]
         end
      end
   end

   // accepted requests move into the control register; reset input clears it
   always_comb begin
      lec_d = lec_q;
      for (int i = 0; i < 4; i++) begin
         if (request_accept_i[i]) begin
            lec_d[i] = enreq_reg[i]; // [RL10]
         end
      end
      if (!reset_in_n_i) begin
         lec_d = 4'h0;
      end
   end

   // interrupt: level, follows current overload flags
   always_comb begin
      irq_n_d = 1'b1; // [RL4]
      if (reset_in_n_i && sel_reg[`LFHP_IRQ_EN_BIT] && |current_overload_flag_i) begin // [RL5]
         irq_n_d = 1'b0; // [RL2] [RL3]
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ale_q   <= 1'b1;
         rsel_q  <= 1'b0;
         wr_q    <= 1'b0;
         wdat_q  <= 4'h0;
         dout_q  <= 4'h0;
         doe_q   <= 4'h0;
         lec_q   <= 4'h0;
         irq_n_q <= 1'b1;
      end else begin
         ale_q   <= ale_d;
         rsel_q  <= rsel_d;
         wr_q    <= wr_d;
         wdat_q  <= wdat_d;
         dout_q  <= dout_d;
         doe_q   <= doe_d;
         lec_q   <= lec_d;
         irq_n_q <= irq_n_d;
      end
   end

   assign data_o            = dout_q;
   assign data_oe_o         = doe_q;
   assign enable_request_o  = enreq_reg;
   assign enable_control_o  = lec_q;
   assign interrupt_out_n_o = irq_n_q;

   property p_irq_assert;
      @(posedge clk_i) disable iff (!arst_n_i)
         (reset_in_n_i && sel_reg[3] && |current_overload_flag_i) |=> !interrupt_out_n_o;
   endproperty
   a_irq_assert: assert property (p_irq_assert) else $error("interrupt not asserted"); // [RL3]

   property p_irq_release;
      @(posedge clk_i) disable iff (!arst_n_i)
         (current_overload_flag_i == 4'h0) |=> interrupt_out_n_o;
   endproperty
   a_irq_release: assert property (p_irq_release) else $error("interrupt not released"); // [RL4]

   property p_irq_reset;
      @(posedge clk_i) disable iff (!arst_n_i)
         !reset_in_n_i |=> interrupt_out_n_o;
   endproperty
   a_irq_reset: assert property (p_irq_reset) else $error("interrupt active in reset"); // [RL5]

   property p_irq_disabled;
      @(posedge clk_i) disable iff (!arst_n_i)
         !sel_reg[3] |=> interrupt_out_n_o;
   endproperty
   a_irq_disabled: assert property (p_irq_disabled) else $error("interrupt while disabled"); // [RL2]

   property p_no_drive_cs;
      @(posedge clk_i) disable iff (!arst_n_i)
         chip_select_n_i |=> (data_oe_o == 4'h0);
   endproperty
   a_no_drive_cs: assert property (p_no_drive_cs) else $error("bus driven without select"); // [RL13]

   property p_drive_on_read;
      @(posedge clk_i) disable iff (!arst_n_i)
         (data_oe_o != 4'h0)
         |-> ($past(chip_select_n_i) == 1'b0 && $past(read_strobe_n_i) == 1'b0);
   endproperty
   a_drive_on_read: assert property (p_drive_on_read) else $error("bus driven outside read"); // [RL14]

   property p_read_sel;
      @(posedge clk_i) disable iff (!arst_n_i)
         (acc == lfhp_pkg::LFHP_ACC_READ && rsel_eff == 1'b0)
         |=> (data_o == {$past(over_temp_i), $past(sel_reg[2:0])});
   endproperty
   a_read_sel: assert property (p_read_sel) else $error("select read data wrong"); // [RL7]

   property p_read_status;
      @(posedge clk_i) disable iff (!arst_n_i)
         (acc == lfhp_pkg::LFHP_ACC_READ && rsel_eff && sel_reg[2:0] == 3'h2)
         |=> (data_o == $past(current_overload_flag_i));
   endproperty
   a_read_status: assert property (p_read_status) else $error("status read data wrong"); // [RL9]

   property p_read_rsv;
      @(posedge clk_i) disable iff (!arst_n_i)
         (acc == lfhp_pkg::LFHP_ACC_READ && rsel_eff && sel_reg[2:1] == 2'b10)
         |=> (data_o == 4'h0);
   endproperty
   a_read_rsv: assert property (p_read_rsv) else $error("reserved code not zero"); // [RL1]

   property p_enreq_write;
      @(posedge clk_i) disable iff (!arst_n_i)
         enreq_load |=> (enable_request_o == $past(wdat_q));
   endproperty
   a_enreq_write: assert property (p_enreq_write) else $error("request write lost"); // [RL10]

   c_sel_write:  cover property (@(posedge clk_i) sel_load);
   c_enreq:      cover property (@(posedge clk_i) enreq_load);
   c_irq:        cover property (@(posedge clk_i) !interrupt_out_n_o);
   c_stat_read:  cover property (@(posedge clk_i) data_oe_o != 4'h0 && rsel_eff);
endmodule

// ---- lfhp_host_model.sv ----
// Purpose: processor side of the four-bit host port
// Assumes: strobes change at the falling clock edge
// Notes:   bus shows the inverse of the last value once released
`timescale 1ns/1ps
`include "lfhp_consts.svh"
module lfhp_host_model #(
   parameter int SETTLE_CYC = `LFHP_REREAD_WAIT_CYC
) (
   input  wire logic       clk_i,
   input  wire logic [3:0] rd_data_i,
   input  wire logic [3:0] rd_oe_i,
   output logic            chip_select_n_o,
   output logic            read_strobe_n_o,
   output logic            write_strobe_n_o,
   output logic            register_select_o,
   output logic      [3:0] data_o
);
   logic settle_due;

   initial begin
      settle_due        = 1'b0;
      chip_select_n_o   = 1'b1;
      read_strobe_n_o   = 1'b1;
      write_strobe_n_o  = 1'b1;
      register_select_o = 1'b0;
      data_o            = 4'h0;
   end

   // select stays put for the whole access, the latch strobe being tied high
   task automatic wr(input logic rs, input logic [3:0] d, input logic chip_select_n);
      @(negedge clk_i);
      chip_select_n_o   = chip_select_n;
      register_select_o = rs;
      data_o            = d;
      write_strobe_n_o  = 1'b0;
      @(negedge clk_i);
      write_strobe_n_o = 1'b1;
      @(negedge clk_i);
      chip_select_n_o = 1'b1;
      data_o          = ~d;
      settle_due      = settle_due || (!chip_select_n && rs);
      @(negedge clk_i);
   endtask

   // a status read right after an enable request write first waits out the settle time
   task automatic rd(input logic rs, output logic [3:0] d, output logic [3:0] oe,
                     input logic chip_select_n);
      if (rs && settle_due) begin
         repeat (SETTLE_CYC) @(negedge clk_i);
         settle_due = 1'b0;
      end
      @(negedge clk_i);
      chip_select_n_o   = chip_select_n;
      register_select_o = rs;
      read_strobe_n_o   = 1'b0;
      @(negedge clk_i);
      d               = rd_data_i;
      oe              = rd_oe_i;
      read_strobe_n_o = 1'b1;
      chip_select_n_o = 1'b1;
   endtask
endmodule

// ---- testbench.sv ----
// Purpose: self-checking bench of the line feed host port
// Assumes: latch strobe tied high, select used live, except in t_latch where the strobe is untied
// Notes:   expectations follow the status code table
`timescale 1ns/1ps
module testbench;
   logic       clk_i      = 1'b0;
   logic       arst_n_i   = 1'b0;
   logic       rst_in_n   = 1'b1;
   logic       over_temp  = 1'b0;
   logic       ale        = 1'b1;
   logic       ale_tied   = 1'b1;
   logic [3:0] pwr_on     = 4'h1;
   logic [3:0] open_lp    = 4'h2;
   logic [3:0] cur_ovl    = 4'h0;
   logic [3:0] therm      = 4'h8;
   logic [3:0] acc        = 4'hf;
   logic [3:0] d;
   logic [3:0] oe;
   wire logic  cs_n, rd_n, wr_n, rs, irq_n;
   wire logic [3:0] hdat, dout, doe, ereq, ectl;
   int         error_cnt       = 0;
   int         samples_checked = 0;

   always #2 clk_i = ~clk_i;

   // settle wait shortened so the whole run stays far below the cycle budget
   lfhp_host_model #(.SETTLE_CYC(64)) host (.clk_i(clk_i), .rd_data_i(dout), .rd_oe_i(doe),
      .chip_select_n_o(cs_n), .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n),
      .register_select_o(rs), .data_o(hdat));

   lfhp_host_port uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .reset_in_n_i(rst_in_n),
      .chip_select_n_i(cs_n), .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n),
      .register_select_i(rs), .addr_latch_i(ale), .addr_latch_tied_i(ale_tied),
      .data_i(hdat), .power_on_phase_flag_i(pwr_on), .open_loop_flag_i(open_lp),
      .current_overload_flag_i(cur_ovl), .thermal_overload_flag_i(therm),
      .request_accept_i(acc), .over_temp_i(over_temp), .data_o(dout),
      .data_oe_o(doe), .enable_request_o(ereq), .enable_control_o(ectl),
      .interrupt_out_n_o(irq_n));

   task automatic chk(input logic [3:0] seen, input logic [3:0] want);
      samples_checked++;
      if (seen !== want) begin
         error_cnt++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic t_reset;
      host.rd(1'b0, d, oe, 1'b0);
      chk(d, 4'h0);
      chk(oe, 4'hf);
      @(negedge clk_i);
      chk(doe, 4'h0);
      chk({3'h0, irq_n}, 4'h1);
      $display("test reset done");
   endtask

   task automatic t_codes;
      logic [3:0] want [8];
      cur_ovl = 4'h4;
      host.wr(1'b1, 4'h5, 1'b0);
      chk(ereq, 4'h5);
      chk(ectl, 4'h5);
      want = '{pwr_on, open_lp, cur_ovl, 4'h5, 4'h0, 4'h0, 4'h5, therm};
      for (int i = 0; i < 8; i++) begin
         host.wr(1'b0, {1'b0, i[2:0]}, 1'b0);
         host.rd(1'b1, d, oe, 1'b0);
         chk(d, want[i]);
         host.rd(1'b0, d, oe, 1'b0);
         chk(d, {1'b0, i[2:0]});
      end
      // only accepted channels move into the control register
      acc = 4'h3;
      host.wr(1'b1, 4'ha, 1'b0);
      chk(ereq, 4'ha);
      chk(ectl, 4'h6);
      acc = 4'hf;
      cur_ovl = 4'h0;
      $display("test status codes done");
   endtask

   task automatic t_irq;
      host.wr(1'b0, 4'h8, 1'b0);
      chk({3'h0, irq_n}, 4'h1);
      cur_ovl = 4'h2;
      repeat (2) @(negedge clk_i);
      chk({3'h0, irq_n}, 4'h0);
      cur_ovl = 4'h0;
      repeat (2) @(negedge clk_i);
      chk({3'h0, irq_n}, 4'h1);
      cur_ovl = 4'h8;
      rst_in_n = 1'b0;
      repeat (2) @(negedge clk_i);
      chk({3'h0, irq_n}, 4'h1);
      rst_in_n = 1'b1;
      repeat (2) @(negedge clk_i);
      chk({3'h0, irq_n}, 4'h0);
      host.wr(1'b0, 4'h0, 1'b0);
      chk({3'h0, irq_n}, 4'h1);
      cur_ovl = 4'h0;
      $display("test interrupt done");
   endtask

   task automatic t_decode;
      over_temp = 1'b1;
      host.wr(1'b0, 4'h5, 1'b0);
      host.wr(1'b0, 4'h2, 1'b1);
      chk(doe, 4'h0);
      host.rd(1'b0, d, oe, 1'b1);
      chk(oe, 4'h0);
      host.rd(1'b0, d, oe, 1'b0);
      chk(d, 4'hd);
      over_temp = 1'b0;
      $display("test decode done");
   endtask

   // select latched high on the strobe fall must outlive a low select during the access
   task automatic t_latch;
      host.wr(1'b0, 4'h1, 1'b0);
      host.rd(1'b1, d, oe, 1'b0);
      chk(d, 4'h2);
      ale_tied = 1'b0;
      @(negedge clk_i);
      ale = 1'b0;
      @(negedge clk_i);
      ale = 1'b1;
      host.rd(1'b0, d, oe, 1'b0);
      chk(d, 4'h2);
      host.wr(1'b0, 4'h5, 1'b0);
      chk(ereq, 4'h5);
      ale_tied = 1'b1;
      host.rd(1'b0, d, oe, 1'b0);
      chk(d, 4'h1);
      $display("test latch done");
   endtask

   initial begin
      repeat (5) @(negedge clk_i);
      arst_n_i = 1'b1;
      t_reset();
      t_codes();
      t_irq();
      t_decode();
      t_latch();
      complete_run();
   end

   initial begin
      #20000;
      error_cnt++;
      complete_run();
   end
endmodule
